// ==== touch_status_slider_volume_regs.v ====
// status bank of the touch controller: press flags, slide direction, slider value,
// volume step and identification, reached through the management bus register port
// assumes the bus engine, sensing logic and power control all run on i_core_clk
`timescale 1ns/100ps
`default_nettype none
`include "touch_status_consts.vh"

module touch_status_slider_volume_regs #(
	parameter       CW             = 8,
	// arbitrary value, stands for the hardware build straps
	parameter [4:0] BUILD_SETTINGS = 5'h03,
	// arbitrary value
	parameter [7:0] MAKER_CODE     = 8'hA5
) (
	// clock and reset
	input  wire            i_core_clk,
	input  wire            i_nrst,
	// register port from the management bus engine
	input  wire [7:0]      i_addr,
	input  wire            i_rd_strobe,
	input  wire            i_wr_strobe,
	input  wire [7:0]      i_wr_data,
	output reg  [7:0]      o_rd_data,
	output reg             o_rd_valid,
	// power state and mode control bits
	input  wire            i_deep_sleep_request,
	input  wire            i_inactive_state_request,
	input  wire            i_location_or_volume_select,
	input  wire            i_auto_repeat_enable,
	input  wire            i_int_clear,
	// sensing results
	input  wire [13:0]     i_press_detect,
	input  wire [13:0]     i_touch_present,
	input  wire [7*CW-1:0] i_slider_strength,
	input  wire            i_slide_up,
	input  wire            i_slide_down,
	input  wire            i_tap_up,
	input  wire            i_tap_down,
	input  wire            i_hold_up,
	input  wire            i_hold_down,
	input  wire            i_slider_active,
	input  wire            i_repeat_tick,
	// outputs
	output reg             o_alert,
	output reg             o_group_status_clear
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg  [13:0] press_flags_reg;
	reg  [13:0] press_flags_next;
	reg         up_flag_reg;
	reg         up_flag_next;
	reg         down_flag_reg;
	reg         down_flag_next;
	reg  [6:0]  position_reg;
	reg  [6:0]  position_next;
	reg  [3:0]  volume_increment_reg;
	reg  [3:0]  volume_increment_next;
	reg         alert_next;
	reg  [7:0]  rd_data_next;
	wire [6:0]  location;
	wire [6:0]  volume;
	wire        clear_all;
	wire        up_event;
	wire        down_event;
	wire        repeat_event;
	wire        slider_event;
	wire        volume_mode;
	wire        rd_slider;
	wire        rd_press_low;
	wire [13:0] new_press;

	assign clear_all    = i_deep_sleep_request | i_inactive_state_request;
	assign up_event     = i_slide_up | i_tap_up | i_hold_up;
	assign down_event   = i_slide_down | i_tap_down | i_hold_down;
	assign repeat_event = i_auto_repeat_enable & i_slider_active & i_repeat_tick;
	assign slider_event = up_event | down_event | repeat_event;
	assign volume_mode  = i_location_or_volume_select;
	assign rd_slider    = i_rd_strobe & (i_addr == `OFS_SLIDER_LOC_OR_VOLUME);
	assign rd_press_low = i_rd_strobe & (i_addr == `OFS_PRESS_FLAGS_LOW);
	// a sensor whose flag is already held does not raise the alert again
	assign new_press    = i_press_detect & ~press_flags_reg;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	slider_locator #(
		.CW         (CW)
	) u_locator (
		.i_strength (i_slider_strength),
		.o_position (location)
	);

	volume_accumulator u_volume (
		.i_core_clk         (i_core_clk),
		.i_nrst             (i_nrst),
		.i_clear            (i_deep_sleep_request),
		.i_preset           (i_wr_strobe & volume_mode &
		                     (i_addr == `OFS_SLIDER_LOC_OR_VOLUME)),
		.i_preset_value     (i_wr_data[6:0]),
		.i_volume_increment (volume_increment_reg),
		.i_slide_up         (volume_mode & i_slide_up),
		.i_slide_down       (volume_mode & i_slide_down),
		.i_unit_up          (volume_mode & (i_tap_up | i_hold_up)),
		.i_unit_down        (volume_mode & (i_tap_down | i_hold_down)),
		.o_volume           (volume)
	);

	// ------------------------------------------------------------
	// press flags
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 14; g = g + 1) begin : g_press
			always @* begin
				press_flags_next[g] = press_flags_reg[g];
				if (i_int_clear && !i_touch_present[g])
					press_flags_next[g] = 1'b0;
				if (i_press_detect[g])
					press_flags_next[g] = 1'b1;
				if (clear_all)
					press_flags_next[g] = 1'b0;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// slide direction flags
	// ------------------------------------------------------------
	always @* begin
		up_flag_next   = up_flag_reg;
		down_flag_next = down_flag_reg;
		if (i_int_clear && !i_slider_active) begin
			up_flag_next   = 1'b0;
			down_flag_next = 1'b0;
		end
		if (up_event) begin
			up_flag_next   = 1'b1;
			down_flag_next = 1'b0;
		end else if (down_event) begin
			down_flag_next = 1'b1;
			up_flag_next   = 1'b0;
		end
		if (clear_all) begin
			up_flag_next   = 1'b0;
			down_flag_next = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// alert output
	// ------------------------------------------------------------
	always @* begin
		alert_next = o_alert;
		if (i_int_clear)
			alert_next = 1'b0;
		if ((|new_press) || up_event || down_event)
			alert_next = 1'b1;
		if (repeat_event)
			alert_next = 1'b1;
		if (clear_all)
			alert_next = 1'b0;
	end

	// ------------------------------------------------------------
	// absolute position
	// ------------------------------------------------------------
	always @* begin
		position_next = position_reg;
		if (rd_slider && !volume_mode)
			position_next = `RST_SLIDER_VALUE;
		// last touched spot wins, reload beats the read clear
		if (slider_event)
			position_next = location;
		if (i_deep_sleep_request)
			position_next = `RST_SLIDER_VALUE;
	end

	// ------------------------------------------------------------
	// step setting
	// ------------------------------------------------------------
	always @* begin
		volume_increment_next = volume_increment_reg;
		if (i_wr_strobe && i_addr == `OFS_VOLUME_INCR_SETTING)
			volume_increment_next = i_wr_data[3:0];
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always @* begin
		case (i_addr)
			`OFS_PRESS_FLAGS_LOW:
				rd_data_next = {up_flag_reg, down_flag_reg, press_flags_reg[5:0]};
			`OFS_PRESS_FLAGS_HIGH:
				rd_data_next = press_flags_reg[13:6];
			`OFS_HW_BUILD_SETTINGS:
				rd_data_next = {3'b000, BUILD_SETTINGS};
			`OFS_SLIDER_LOC_OR_VOLUME:
				rd_data_next = {1'b0, volume_mode ? volume : position_reg};
			`OFS_MAKER_IDENT:
				rd_data_next = MAKER_CODE;
			`OFS_VOLUME_INCR_SETTING:
				rd_data_next = {4'h0, volume_increment_reg};
			default:
				rd_data_next = `UNMAPPED_READ_VALUE;
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always @(posedge i_core_clk) begin
		if (!i_nrst) begin
			press_flags_reg      <= {6'h00, `RST_PRESS_FLAGS};
			up_flag_reg          <= 1'b0;
			down_flag_reg        <= 1'b0;
			position_reg         <= `RST_SLIDER_VALUE;
			volume_increment_reg <= `RST_VOLUME_INCREMENT;
			o_alert              <= 1'b0;
			o_rd_data            <= 8'h00;
			o_rd_valid           <= 1'b0;
			o_group_status_clear <= 1'b0;
		end else begin
			press_flags_reg      <= press_flags_next;
			up_flag_reg          <= up_flag_next;
			down_flag_reg        <= down_flag_next;
			position_reg         <= position_next;
			volume_increment_reg <= volume_increment_next;
			o_alert              <= alert_next;
			o_rd_data            <= i_rd_strobe ? rd_data_next : o_rd_data;
			o_rd_valid           <= i_rd_strobe;
			o_group_status_clear <= rd_press_low;
		end
	end

endmodule // touch_status_slider_volume_regs
`default_nettype wire

// ==== touch_status_consts.vh ====
// register offsets, field positions, reset values and limits of the touch status block
// assumes inclusion by the status bank and its helper modules
`ifndef TOUCH_STATUS_CONSTS_VH
`define TOUCH_STATUS_CONSTS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_PRESS_FLAGS_LOW       8'h03
`define OFS_PRESS_FLAGS_HIGH      8'h04
`define OFS_HW_BUILD_SETTINGS     8'h05
`define OFS_SLIDER_LOC_OR_VOLUME  8'h06
`define OFS_MAKER_IDENT           8'h08
`define OFS_VOLUME_INCR_SETTING   8'h09

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define BIT_SLIDE_UP              7
`define BIT_SLIDE_DOWN            6
`define RST_PRESS_FLAGS           8'h00
`define RST_SLIDER_VALUE          7'h00
`define RST_VOLUME_INCREMENT      4'h1
`define UNMAPPED_READ_VALUE       8'h00

// ------------------------------------------------------------
// slider geometry and volume range
// ------------------------------------------------------------
`define SLIDER_SENSORS            7
`define SLIDER_STEPS_PER_SENSOR   16
`define SLIDER_POS_MIN            7'h02
`define SLIDER_POS_MAX            7'h62
`define VOLUME_MIN                7'h00
`define VOLUME_MAX                7'h64

`endif

// ==== slider_locator.v ====
// interpolates the absolute touch position along the grouped slider sensors
// assumes per-sensor strength counts from the sensing logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "touch_status_consts.vh"

module slider_locator #(
	parameter CW = 8
) (
	// strength counts, sensor 0 in the low slice
	input  wire [7*CW-1:0] i_strength,
	// interpolated position
	output reg  [6:0]      o_position
);

	reg [CW-1:0] left;
	reg [CW-1:0] centre;
	reg [CW-1:0] right;
	reg [CW-1:0] best;
	reg [2:0]    peak;
	reg signed [CW+5:0] diff;
	reg signed [CW+5:0] total;
	reg signed [CW+5:0] offs;
	reg signed [CW+5:0] pos;
	integer k;
	localparam integer  HALF_PITCH = `SLIDER_STEPS_PER_SENSOR / 2;
	localparam [CW+5:0] POS_LO     = {{(CW-1){1'b0}}, `SLIDER_POS_MIN};
	localparam [CW+5:0] POS_HI     = {{(CW-1){1'b0}}, `SLIDER_POS_MAX};

	always @* begin
		best   = {CW{1'b0}};
		peak   = 3'd0;
		left   = {CW{1'b0}};
		right  = {CW{1'b0}};
		for (k = 0; k < `SLIDER_SENSORS; k = k + 1) begin
			if (i_strength[k*CW +: CW] > best) begin
				best = i_strength[k*CW +: CW];
				peak = k[2:0];
			end
		end
		centre = best;
		// up to three adjacent sensors take part
		if (peak != 3'd0)
			left = i_strength[(peak-3'd1)*CW +: CW];
		if (peak != 3'd6)
			right = i_strength[(peak+3'd1)*CW +: CW];
		diff  = $signed({6'b0, right}) - $signed({6'b0, left});
		total = $signed({6'b0, left}) + $signed({6'b0, centre}) + $signed({6'b0, right});
		// half a sensor pitch at most either way
		if (total == {(CW+6){1'b0}})
			offs = {(CW+6){1'b0}};
		else
			offs = (diff * $signed(HALF_PITCH[CW+5:0])) / total;
		pos = $signed({{(CW+2){1'b0}}, peak, 1'b0}) * $signed(HALF_PITCH[CW+5:0])
			+ $signed(POS_LO) + offs;
		if (pos < $signed(POS_LO))
			o_position = `SLIDER_POS_MIN;
		else if (pos > $signed(POS_HI))
			o_position = `SLIDER_POS_MAX;
		else
			o_position = pos[6:0];
	end

endmodule // slider_locator
`default_nettype wire

// ==== volume_accumulator.v ====
// saturating volume value driven by slider events and host presets
// assumes one-cycle event pulses from the same clock
`timescale 1ns/100ps
`default_nettype none
`include "touch_status_consts.vh"

module volume_accumulator (
	// clock and reset
	input  wire       i_core_clk,
	input  wire       i_nrst,
	// control
	input  wire       i_clear,
	input  wire       i_preset,
	input  wire [6:0] i_preset_value,
	input  wire [3:0] i_volume_increment,
	// events
	input  wire       i_slide_up,
	input  wire       i_slide_down,
	input  wire       i_unit_up,
	input  wire       i_unit_down,
	// value
	output reg  [6:0] o_volume
);

	reg  [6:0] volume_next;
	reg  [7:0] sum;
	reg  [7:0] amount;
	reg        up;

	always @* begin
		amount = 8'h00;
		up     = 1'b0;
		if (i_slide_up) begin
			amount = {4'h0, i_volume_increment};
			up     = 1'b1;
		end else if (i_slide_down) begin
			amount = {4'h0, i_volume_increment};
		end else if (i_unit_up) begin
			amount = 8'h01;
			up     = 1'b1;
		end else if (i_unit_down) begin
			amount = 8'h01;
		end
		sum = 8'h00;
		volume_next = o_volume;
		if (up) begin
			sum = {1'b0, o_volume} + amount;
			if (sum > {1'b0, `VOLUME_MAX})
				volume_next = `VOLUME_MAX;
			else
				volume_next = sum[6:0];
		end else if (amount != 8'h00) begin
			if (amount > {1'b0, o_volume})
				volume_next = `VOLUME_MIN;
			else
				volume_next = o_volume - amount[6:0];
		end
		if (i_preset)
			volume_next = (i_preset_value > `VOLUME_MAX) ? `VOLUME_MAX : i_preset_value;
		if (i_clear)
			volume_next = `RST_SLIDER_VALUE;
	end

	always @(posedge i_core_clk) begin
		if (!i_nrst)
			o_volume <= `RST_SLIDER_VALUE;
		else
			o_volume <= volume_next;
	end

endmodule // volume_accumulator
`default_nettype wire

// ==== touch_regs_sva.sv ====
// concurrent checks on the register port and alert of the touch status bank
// assumes it is bound onto touch_status_slider_volume_regs
`timescale 1ns/100ps
`default_nettype none
module touch_regs_sva #(
	parameter [4:0] BUILD_SETTINGS = 5'h03,
	parameter [7:0] MAKER_CODE     = 8'hA5
) (
	// clock and reset
	input wire logic        i_core_clk,
	input wire logic        i_nrst,
	// register port
	input wire logic [7:0]  i_addr,
	input wire logic        i_rd_strobe,
	input wire logic [7:0]  o_rd_data,
	input wire logic        o_rd_valid,
	// control and events
	input wire logic        i_deep_sleep_request,
	input wire logic        i_inactive_state_request,
	input wire logic        i_int_clear,
	input wire logic [13:0] i_press_detect,
	input wire logic        i_slide_up,
	input wire logic        i_slide_down,
	input wire logic        i_tap_up,
	input wire logic        i_tap_down,
	input wire logic        i_hold_up,
	input wire logic        i_hold_down,
	input wire logic        i_repeat_tick,
	input wire logic        o_alert,
	input wire logic        o_group_status_clear
);
// ------------------------------------------------------------
// properties
// ------------------------------------------------------------
default clocking @(posedge i_core_clk); endclocking
default disable iff (!i_nrst);
wire rd3 = i_rd_strobe && i_addr == 8'h03;
wire quiet = i_press_detect == 14'h0000 && !(i_slide_up || i_slide_down || i_tap_up
	|| i_tap_down || i_hold_up || i_hold_down || i_repeat_tick);
chk_rd_answer: assert property (i_rd_strobe |=> o_rd_valid)
	else $error("read not answered");
chk_rd_pulse: assert property (o_rd_valid |-> $past(i_rd_strobe))
	else $error("read valid without read");
chk_rd_hold: assert property (!i_rd_strobe |=> $stable(o_rd_data))
	else $error("read data moved without read");
chk_grp_clear: assert property (rd3 |=> o_group_status_clear)
	else $error("group clear missing");
chk_grp_only: assert property (o_group_status_clear |-> $past(rd3))
	else $error("group clear without read");
chk_build_read: assert property (i_rd_strobe && i_addr == 8'h05 |=> o_rd_data == {3'h0, BUILD_SETTINGS})
	else $error("build byte wrong");
chk_maker_read: assert property (i_rd_strobe && i_addr == 8'h08 |=> o_rd_data == MAKER_CODE)
	else $error("maker byte wrong");
chk_step_nibble: assert property (i_rd_strobe && i_addr == 8'h09 |=> o_rd_data[7:4] == 4'h0)
	else $error("step upper bits set");
chk_slider_msb: assert property (i_rd_strobe && i_addr == 8'h06 |=> !o_rd_data[7])
	else $error("slider bit seven set");
chk_power_quiet: assert property (i_deep_sleep_request || i_inactive_state_request |=> !o_alert)
	else $error("alert kept in low power");
chk_int_clear: assert property (i_int_clear && quiet |=> !o_alert)
	else $error("alert kept after clear");
cover property (rd3 ##1 o_group_status_clear);
cover property (i_int_clear ##1 !o_alert);
cover property (i_repeat_tick ##1 o_alert);
endmodule // touch_regs_sva
bind touch_status_slider_volume_regs touch_regs_sva #(
	.BUILD_SETTINGS(BUILD_SETTINGS),
	.MAKER_CODE(MAKER_CODE)
) u_sva (.i_core_clk, .i_nrst, .i_addr, .i_rd_strobe, .o_rd_data, .o_rd_valid,
	.i_deep_sleep_request, .i_inactive_state_request, .i_int_clear, .i_press_detect,
	.i_slide_up, .i_slide_down, .i_tap_up, .i_tap_down, .i_hold_up, .i_hold_down,
	.i_repeat_tick, .o_alert, .o_group_status_clear);
`default_nettype wire

// ==== host_bus_model.sv ====
// host side of the register port: single byte reads and writes
// assumes strobes are taken on the rising edge of i_core_clk
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
	input  wire logic       i_core_clk,
	output var  logic [7:0] o_addr,
	output var  logic       o_rd_strobe,
	output var  logic       o_wr_strobe,
	output var  logic [7:0] o_wr_data,
	input  wire logic [7:0] i_rd_data,
	input  wire logic       i_rd_valid
);
// ------------------------------------------------------------
// bus tasks
// ------------------------------------------------------------
initial begin
	o_addr = 8'h00;
	o_rd_strobe = 1'b0;
	o_wr_strobe = 1'b0;
	o_wr_data = 8'h00;
end
task wr(input [7:0] a, input [7:0] d);
	@(posedge i_core_clk);
	o_addr <= a;
	o_wr_data <= d;
	o_wr_strobe <= 1'b1;
	@(posedge i_core_clk);
	o_wr_strobe <= 1'b0;
	o_wr_data <= ~d;
	o_addr <= ~a;
endtask
task rd(input [7:0] a, output [7:0] d);
	integer n;
	@(posedge i_core_clk);
	o_addr <= a;
	o_rd_strobe <= 1'b1;
	@(posedge i_core_clk);
	o_rd_strobe <= 1'b0;
	o_addr <= ~a;
	#1;
	n = 0;
	while (i_rd_valid !== 1'b1 && n < 4) begin
		@(posedge i_core_clk);
		#1;
		n = n + 1;
	end
	d = i_rd_data;
endtask
endmodule // host_bus_model
`default_nettype wire

// ==== touch_status_slider_volume_regs_test.sv ====
// self-checking bench of the touch status bank against a behavioural model
// assumes host_bus_model and the bound checker alongside
`timescale 1ns/100ps
`default_nettype none
module touch_status_slider_volume_regs_test;
// ------------------------------------------------------------
// stimulus, model and checks
// ------------------------------------------------------------
localparam [4:0] BLD = 5'h0B; // arbitrary value
localparam [7:0] MKR = 8'h3C; // arbitrary value
logic clk = 1'b0, nrst = 1'b0, rd, wr, rvalid, alert, gclr;
logic [7:0] addr, wdata, rdata, d;
logic sleep = 0, inact = 0, volsel = 0, arep = 0, iclr = 0, act = 0, tick = 0;
logic [13:0] press = 0, touch = 0, mf = 0;
logic [55:0] strength = 0;
logic [5:0] ev = 0;
logic mu = 0, md = 0, ma = 0;
integer n_mismatch = 0, checks = 0, seed = 8, vol = 0, stp = 1, i;
always #10 clk = ~clk;
touch_status_slider_volume_regs #(.CW(8), .BUILD_SETTINGS(BLD), .MAKER_CODE(MKR)) DUT (
	.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_rd_strobe(rd), .i_wr_strobe(wr),
	.i_wr_data(wdata), .o_rd_data(rdata), .o_rd_valid(rvalid),
	.i_deep_sleep_request(sleep), .i_inactive_state_request(inact),
	.i_location_or_volume_select(volsel), .i_auto_repeat_enable(arep), .i_int_clear(iclr),
	.i_press_detect(press), .i_touch_present(touch), .i_slider_strength(strength),
	.i_slide_up(ev[0]), .i_slide_down(ev[1]), .i_tap_up(ev[2]), .i_tap_down(ev[3]),
	.i_hold_up(ev[4]), .i_hold_down(ev[5]), .i_slider_active(act), .i_repeat_tick(tick),
	.o_alert(alert), .o_group_status_clear(gclr));
host_bus_model host (.i_core_clk(clk), .o_addr(addr), .o_rd_strobe(rd), .o_wr_strobe(wr),
	.o_wr_data(wdata), .i_rd_data(rdata), .i_rd_valid(rvalid));
task results;
	$display("mismatches %0d checks %0d", n_mismatch, checks);
	if (checks > 0 && n_mismatch == 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
task cmp_data(input [7:0] got, input [7:0] exp);
	checks = checks + 1;
	if (got !== exp) begin
		n_mismatch = n_mismatch + 1;
		$display("CHECK FAILED %0t read %h want %h", $time, got, exp);
	end
endtask
task cmp_flag(input got, input exp);
	checks = checks + 1;
	if (got !== exp) begin
		n_mismatch = n_mismatch + 1;
		$display("CHECK FAILED %0t flag %b want %b", $time, got, exp);
	end
endtask
task rdc(input [7:0] a, input [7:0] e);
	host.rd(a, d);
	cmp_data(d, e);
	cmp_flag(rvalid, 1'b1);
	cmp_flag(gclr, a == 8'h03);
endtask
task press_on(input [13:0] p);
	@(posedge clk);
	press <= p;
	@(posedge clk);
	press <= 14'h0000;
	#1;
	ma = ma | (|(p & ~mf));
	mf = mf | p;
	cmp_flag(alert, ma);
endtask
task int_clear;
	@(posedge clk);
	iclr <= 1'b1;
	@(posedge clk);
	iclr <= 1'b0;
	#1;
	mf = mf & touch;
	if (!act) {mu, md} = 2'b00;
	ma = 1'b0;
	cmp_flag(alert, 1'b0);
endtask
task pwr(input deep);
	@(posedge clk);
	sleep <= deep;
	inact <= !deep;
	@(posedge clk);
	sleep <= 1'b0;
	inact <= 1'b0;
	#1;
	{mf, mu, md, ma} = 0;
	if (deep) vol = 0;
	cmp_flag(alert, 1'b0);
endtask
task fire(input [5:0] v);
	@(posedge clk);
	ev <= v;
	@(posedge clk);
	ev <= 6'h00;
	#1;
	mu = |(v & 6'h15);
	md = !mu;
	if (volsel) vol = vol + (v[0] ? stp : v[1] ? -stp : mu ? 1 : -1);
	if (vol > 100) vol = 100;
	if (vol < 0) vol = 0;
	ma = 1'b1;
	cmp_flag(alert, ma);
endtask
initial begin
	repeat (5) @(posedge clk);
	nrst <= 1'b1;
	rdc(8'h03, 8'h00);
	rdc(8'h04, 8'h00);
	rdc(8'h09, 8'h01);
	rdc(8'h06, 8'h00);
	rdc(8'h05, {3'h0, BLD});
	rdc(8'h08, MKR);
	rdc(8'h07, 8'h00);
	host.wr(8'h05, 8'hFF);
	rdc(8'h05, {3'h0, BLD});
	host.wr(8'h09, 8'hF7);
	rdc(8'h09, 8'h07);
	for (i = 0; i < 4; i = i + 1) begin
		@(posedge clk);
		touch <= 14'($random(seed));
		press_on(14'($random(seed)));
		rdc(8'h03, {mu, md, mf[5:0]});
		rdc(8'h04, mf[13:6]);
		int_clear();
		rdc(8'h03, {mu, md, mf[5:0]});
		rdc(8'h04, mf[13:6]);
	end
	for (i = 0; i < 6; i = i + 1) begin
		fire(6'h01 << i);
		rdc(8'h03, {mu, md, mf[5:0]});
	end
	for (i = 0; i < 7; i = i + 1) begin
		@(posedge clk);
		strength <= 56'hFF << (8 * i);
		fire(6'h01);
		rdc(8'h06, 8'(16 * i + 2));
		rdc(8'h06, 8'h00);
	end
	host.wr(8'h06, 8'h2A);
	rdc(8'h06, 8'h00);
	@(posedge clk);
	arep <= 1'b1;
	act <= 1'b1;
	int_clear();
	@(posedge clk);
	tick <= 1'b1;
	@(posedge clk);
	tick <= 1'b0;
	#1;
	cmp_flag(alert, 1'b1);
	@(posedge clk);
	act <= 1'b0;
	pwr(1'b0);
	rdc(8'h03, 8'h00);
	@(posedge clk);
	volsel <= 1'b1;
	host.wr(8'h09, 8'h0F);
	stp = 15;
	host.wr(8'h06, 8'h7F);
	rdc(8'h06, 8'h64);
	host.wr(8'h06, 8'h3C);
	vol = 60;
	rdc(8'h06, 8'h3C);
	for (i = 0; i < 40; i = i + 1) begin
		fire(i < 4 ? 6'h01 : i < 12 ? 6'h02 : 6'h01 << ($unsigned($random(seed)) % 6));
		rdc(8'h06, 8'(vol));
	end
	pwr(1'b1);
	rdc(8'h06, 8'h00);
	rdc(8'h03, 8'h00);
	results();
end
initial begin
	#400000;
	n_mismatch = n_mismatch + 1;
	results();
end
endmodule // touch_status_slider_volume_regs_test
`default_nettype wire
